/* core/usb_endpoint_rx_status_tx_count.sv */
/*
  Endpoint receive-status flags, function address and transmit byte/count port of a
  full-speed USB device, with an Avalon-MM register slave and an event interrupt.
  Assumes the serial engine and FIFO logic sit outside and signal synchronously to clk.

*/
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_rx_status_tx_count
	import usb_ep_pkg::*;
(
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// Avalon-MM slave
	input  wire logic [usb_ep_pkg::ADDR_W-1:0] address,
	input  wire logic                          read,
	input  wire logic                          write,
	input  wire logic [31:0]                   writedata,
	input  wire logic [3:0]                    byteenable,
	output logic      [31:0]                   readdata,
	output logic                               waitrequest,
	// Serial engine side
	input  wire logic                          tokStrobe,
	input  wire usb_ep_pkg::token_t            tokInfo,
	input  wire usb_ep_pkg::rxFifoState_t      rxFifo,
	input  wire logic                          rxDone,
	input  wire usb_ep_pkg::rxResult_t         rxResult,
	input  wire logic                          sof,
	input  wire logic                          usbReset,
	input  wire logic                          txSetSent,
	input  wire logic [usb_ep_pkg::EP_W-1:0]   txSentEp,
	output usb_ep_pkg::handshake_t             handshake,
	// Transmit FIFO write port
	output logic                               txByteWe,
	output logic      [7:0]                    txByteData,
	output logic      [usb_ep_pkg::EP_W-1:0]   txByteEp,
	output logic      [usb_ep_pkg::PTR_W-1:0]  txWrPtr,
	// Interrupt
	output logic                               irq
);
	import usb_ep_pkg::*;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic [IDX_W-1:0] idx;
	logic             accept;
	logic             wrEn;
	logic [7:0]       wd;
	logic [7:0]       rdMux;
	logic [EP_W-1:0]  endpointSelect_q;
	logic [CFG_W-1:0] rxCfg_q [NUM_EP];
	logic             enhancedFeatureBit_q;
	logic [DEVICE_BUS_ADDRESS_W-1:0] functionAddressReg_q;
	logic [EVT_W-1:0] evtA_q, evtB_q, maskA_q, maskB_q;
	logic [1:0]       txFilledSets_q [NUM_EP];
	logic [SLOT_W-1:0] txWrSlot_q [NUM_EP];
	logic [SLOT_W-1:0] txRdSlot_q [NUM_EP];
	logic [CNT_W-1:0] txByteCount_q [NUM_EP][SLOTS];
	logic [PTR_W-1:0] txPtr_q [NUM_EP];
	logic [1:0]       selFilled;
	logic [CNT_W-1:0] selCount;
	txnState_t        state_q;
	token_t           cur_q;
	logic             curVoid_q, curSetup_q, curStall_q;
	logic             finish, anyErr, voidNow, tokSetupPend;
	logic [CFG_W-1:0] tokCfg;
	rxOutcome_t       outcome;
	logic [NUM_EP-1:0] endNow, isoEnd, setupSet, setupClr;
	logic [NUM_EP-1:0] rx_void_flag, rx_error_flag, rx_ack_flag, setupPend, doneEvt;

	// Bus decode; one wait cycle then the access completes
	assign idx       = address[ADDR_W-1:ADDR_LSB];
	assign accept    = (read | write) & ~waitrequest;
	assign wrEn      = write & accept & byteenable[0];
	assign wd        = writedata[7:0];
	assign selFilled = txFilledSets_q[endpointSelect_q];
	assign selCount  = txByteCount_q[endpointSelect_q][txWrSlot_q[endpointSelect_q]];

	// Wait state generator
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= ~((read | write) & waitrequest);
		end
	end

	// Read mux; unmapped slots read zero
	always_comb begin
		rdMux = '0;
		case (idx)
			IDX_CNT_LOW:   rdMux = selCount[7:0];
			IDX_CNT_HIGH:  rdMux[CNT_HI_W-1:0] = selCount[CNT_W-1:8];
			IDX_RX_STATUS: begin
				rdMux[RXS_SETUP] = setupPend[endpointSelect_q];
				rdMux[RXS_VOID]  = rx_void_flag[endpointSelect_q];
				rdMux[RXS_ERR]   = rx_error_flag[endpointSelect_q];
				rdMux[RXS_ACK]   = rx_ack_flag[endpointSelect_q];
			end
			IDX_DEVICE_BUS_ADDRESS:     rdMux[DEVICE_BUS_ADDRESS_W-1:0] = functionAddressReg_q;
			IDX_EP_SELECT: rdMux[EP_W-1:0] = endpointSelect_q;
			IDX_RX_CFG:    rdMux[CFG_W-1:0] = rxCfg_q[endpointSelect_q];
			IDX_DEV_CFG:   rdMux[DEV_FEAT] = enhancedFeatureBit_q;
			IDX_EVT_A:     rdMux = evtA_q;
			IDX_EVT_B:     rdMux = evtB_q;
			IDX_MASK_A:    rdMux = maskA_q;
			IDX_MASK_B:    rdMux = maskB_q;
			IDX_TX_FILLED: rdMux[1:0] = selFilled;
			default:       rdMux = '0;
		endcase
	end

	// Read data captured in the wait cycle, stands at the completing edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			readdata <= '0;
		end else if (read & waitrequest) begin
			readdata <= {24'h000000, rdMux};
		end
	end

	// Configuration registers written by firmware
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			endpointSelect_q     <= '0;
			enhancedFeatureBit_q <= 1'b0;
			maskA_q              <= '0;
			maskB_q              <= '0;
			for (int e = 0; e < NUM_EP; e++) rxCfg_q[e] <= '0;
		end else if (wrEn) begin
			case (idx)
				IDX_EP_SELECT: endpointSelect_q <= wd[EP_W-1:0];
				IDX_RX_CFG:    rxCfg_q[endpointSelect_q] <= wd[CFG_W-1:0];
				IDX_DEV_CFG:   enhancedFeatureBit_q <= wd[DEV_FEAT];
				IDX_MASK_A:    maskA_q <= wd;
				IDX_MASK_B:    maskB_q <= wd;
				default:       ;
			endcase
		end
	end

	// bus reset clears address only with the enhanced feature
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			functionAddressReg_q <= '0;
		end else if (usbReset & enhancedFeatureBit_q) begin
			functionAddressReg_q <= '0;
		end else if (wrEn && idx == IDX_DEVICE_BUS_ADDRESS) begin
			functionAddressReg_q <= wd[DEVICE_BUS_ADDRESS_W-1:0];
		end
	end

	// event bits: read clears what was shown, a new event wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evtA_q <= '0;
			evtB_q <= '0;
		end else begin
			evtA_q <= (evtA_q & ~((read && accept && idx == IDX_EVT_A) ? readdata[7:0] : 8'h00))
				| doneEvt[EVT_W-1:0];
			evtB_q <= (evtB_q & ~((read && accept && idx == IDX_EVT_B) ? readdata[7:0] : 8'h00))
				| doneEvt[NUM_EP-1:EVT_W];
		end
	end

	// Level interrupt from unmasked events
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |({evtB_q, evtA_q} & {maskB_q, maskA_q});
		end
	end

	// byte port write, refused while every set is filled
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			txByteWe   <= 1'b0;
			txByteData <= '0;
			txByteEp   <= '0;
			txWrPtr    <= '0;
			for (int e = 0; e < NUM_EP; e++) txPtr_q[e] <= '0;
		end else begin
			txByteWe <= 1'b0;
			if (wrEn && idx == IDX_TX_BYTE && selFilled != SETS_FULL) begin
				txByteWe   <= 1'b1;
				txByteData <= wd;
				txByteEp   <= endpointSelect_q;
				txWrPtr    <= txPtr_q[endpointSelect_q];
				txPtr_q[endpointSelect_q] <= txPtr_q[endpointSelect_q] + 10'h001;
			end
		end
	end

	// count ring: high then low, low validates the set
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int e = 0; e < NUM_EP; e++) begin
				txFilledSets_q[e] <= '0;
				txWrSlot_q[e]     <= '0;
				txRdSlot_q[e]     <= '0;
				for (int s = 0; s < SLOTS; s++) txByteCount_q[e][s] <= '0;
			end
		end else begin
			for (int e = 0; e < NUM_EP; e++) begin
				logic inc;
				logic dec;
				inc = wrEn && idx == IDX_CNT_LOW && endpointSelect_q == EP_W'(e)
					&& txFilledSets_q[e] != SETS_FULL;
				dec = txSetSent && txSentEp == EP_W'(e) && txFilledSets_q[e] != '0;
				if (inc) begin
					txByteCount_q[e][txWrSlot_q[e]][7:0] <= wd;
					txWrSlot_q[e] <= txWrSlot_q[e] + 2'h1;
				end
				if (wrEn && idx == IDX_CNT_HIGH && endpointSelect_q == EP_W'(e)) begin
					txByteCount_q[e][txWrSlot_q[e]][CNT_W-1:8] <= wd[CNT_HI_W-1:0];
				end
				if (dec) begin
					txRdSlot_q[e] <= txRdSlot_q[e] + 2'h1;
				end
				if (inc & ~dec) begin
					txFilledSets_q[e] <= txFilledSets_q[e] + 2'h1;
				end else if (dec & ~inc) begin
					txFilledSets_q[e] <= txFilledSets_q[e] - 2'h1;
				end
			end
		end
	end

	// void condition of the token's endpoint
	assign tokCfg       = rxCfg_q[tokInfo.ep];
	assign tokSetupPend = setupPend[tokInfo.ep];
	assign voidNow      = ~tokCfg[CFG_IE] | tokCfg[CFG_STALL] | tokSetupPend
		| (rxFifo.rxFilledSets == SETS_FULL)
		| ((^rxFifo.rxFilledSets) & tokCfg[CFG_SPM])
		| rxFifo.rxUnderrunFlag | rxFifo.rxOverrunFlag;
	assign anyErr  = rxResult.crcErr | rxResult.stuffErr | rxResult.fifoErr;
	assign finish  = (state_q == ST_DATA) & rxDone;
	assign outcome = '{voidHit: curVoid_q & (cur_q.kind == TOK_OUT), err: anyErr};

	// Transaction tracker and handshake choice
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q    <= ST_IDLE;
			cur_q      <= '{kind: TOK_OUT, ep: '0, iso: 1'b0};
			curVoid_q  <= 1'b0;
			curSetup_q <= 1'b0;
			curStall_q <= 1'b0;
			handshake  <= '0;
		end else begin
			handshake <= '0;
			unique case (state_q)
				ST_IDLE: begin
					if (tokStrobe) begin
						cur_q      <= tokInfo;
						curVoid_q  <= voidNow;
						curSetup_q <= tokSetupPend;
						curStall_q <= tokCfg[CFG_STALL];
						// IN held off while setup pending
						if (tokInfo.kind == TOK_IN) begin
							handshake.nak <= tokSetupPend;
						end else begin
							state_q <= ST_DATA;
						end
					end
				end
				ST_DATA: begin
					if (rxDone) begin
						state_q <= ST_IDLE;
						if (cur_q.iso) begin
							handshake <= '0;
						// OUT NAKed while setup pending, even if stalled
						end else if (outcome.voidHit) begin
							handshake.nak   <= curSetup_q | ~curStall_q;
							handshake.stall <= ~curSetup_q & curStall_q;
						end else begin
							handshake.ack <= ~anyErr;
						end
					end
				end
			endcase
		end
	end

	// Per-endpoint steering of results
	always_comb begin
		for (int e = 0; e < NUM_EP; e++) begin
			endNow[e]   = finish && !cur_q.iso && cur_q.ep == EP_W'(e);
			isoEnd[e]   = finish && cur_q.iso && cur_q.ep == EP_W'(e);
			// valid SETUP token marks the endpoint
			setupSet[e] = tokStrobe && state_q == ST_IDLE && tokInfo.kind == TOK_SETUP
				&& tokInfo.ep == EP_W'(e);
			setupClr[e] = wrEn && idx == IDX_RX_STATUS && endpointSelect_q == EP_W'(e)
				&& !wd[RXS_SETUP];
		end
	end

	for (genvar g = 0; g < NUM_EP; g++) begin : gEp
		rx_ep_status uStatus (
			.clk              (clk),
			.rst_n            (rst_n),
			.endNow           (endNow[g]),
			.isoEnd           (isoEnd[g]),
			.sof              (sof),
			.outcome          (outcome),
			.setupSet         (setupSet[g]),
			.setupClr         (setupClr[g]),
			.rxVoidFlag       (rx_void_flag[g]),
			.rxErrorFlag      (rx_error_flag[g]),
			.rxAckFlag        (rx_ack_flag[g]),
			.setupPendingFlag (setupPend[g]),
			.rxDoneEventBit   (doneEvt[g])
		);
	end

	sequence sErrEnd;
		finish && anyErr && !outcome.voidHit;
	endsequence
	sequence sVoidOutEnd;
		finish && !cur_q.iso && outcome.voidHit;
	endsequence

	chk_void_refuses_out: assert property (sVoidOutEnd |=> handshake.nak || handshake.stall)
		else $error("void OUT not refused");
	chk_err_no_hs: assert property (sErrEnd |=> handshake == '0)
		else $error("handshake sent on errored data");
	chk_device_bus_address_bit7: assert property (read && waitrequest && idx == IDX_DEVICE_BUS_ADDRESS
		|=> !readdata[DEVICE_BUS_ADDRESS_W] ##0 !waitrequest)
		else $error("address reserved bit not zero");
	chk_device_bus_address_busreset: assert property (usbReset && enhancedFeatureBit_q
		|=> functionAddressReg_q == '0)
		else $error("address kept over bus reset");
	chk_byte_port_write: assert property (wrEn && idx == IDX_TX_BYTE && selFilled != SETS_FULL
		|=> txByteWe && txByteData == $past(wd) && txByteEp == $past(endpointSelect_q))
		else $error("byte port write not forwarded");
	chk_count_low_inc: assert property (wrEn && idx == IDX_CNT_LOW && selFilled != SETS_FULL
		&& !txSetSent |=> selFilled == $past(selFilled) + 2'h1)
		else $error("filled sets not incremented");
	chk_count_high_rsvd: assert property (read && waitrequest && idx == IDX_CNT_HIGH
		|=> readdata[7:CNT_HI_W] == '0)
		else $error("count reserved bits not zero");
	chk_setup_nak_in: assert property (tokStrobe && state_q == ST_IDLE && tokInfo.kind == TOK_IN
		&& tokSetupPend |=> handshake.nak ##1 !handshake.nak)
		else $error("IN not NAKed during setup pending");
	chk_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("bus access not completed");
endmodule
`default_nettype wire

/* core/usb_ep_pkg.sv */
/*
  Shared constants and carriers for the endpoint receive-status and transmit-count block.
  Assumes one core clock and word-aligned register slots on a 32-bit bus.
*/
`default_nettype none
package usb_ep_pkg;
	// Sizes
	localparam int NUM_EP  = 16;
	localparam int EP_W    = 4;
	localparam int CNT_W   = 10;
	localparam int CNT_HI_W = 2;
	localparam int SLOT_W  = 2;
	localparam int SLOTS   = 4;
	localparam int PTR_W   = 10;
	localparam int ADDR_W  = 7;
	localparam int ADDR_LSB = 2;
	localparam int IDX_W   = 5;
	localparam int DEVICE_BUS_ADDRESS_W = 7;
	localparam int EVT_W   = 8;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_TX_BYTE   = 5'h00;
	localparam logic [IDX_W-1:0] IDX_CNT_LOW   = 5'h01;
	localparam logic [IDX_W-1:0] IDX_CNT_HIGH  = 5'h02;
	localparam logic [IDX_W-1:0] IDX_RX_STATUS = 5'h0d;
	localparam logic [IDX_W-1:0] IDX_DEVICE_BUS_ADDRESS     = 5'h10;
	localparam logic [IDX_W-1:0] IDX_EP_SELECT = 5'h11;
	localparam logic [IDX_W-1:0] IDX_RX_CFG    = 5'h12;
	localparam logic [IDX_W-1:0] IDX_DEV_CFG   = 5'h13;
	localparam logic [IDX_W-1:0] IDX_EVT_A     = 5'h14;
	localparam logic [IDX_W-1:0] IDX_EVT_B     = 5'h15;
	localparam logic [IDX_W-1:0] IDX_MASK_A    = 5'h16;
	localparam logic [IDX_W-1:0] IDX_MASK_B    = 5'h17;
	localparam logic [IDX_W-1:0] IDX_TX_FILLED = 5'h18;

	// Field positions
	localparam int RXS_SETUP = 6;
	localparam int RXS_VOID  = 2;
	localparam int RXS_ERR   = 1;
	localparam int RXS_ACK   = 0;
	localparam int CFG_IE    = 0;
	localparam int CFG_STALL = 1;
	localparam int CFG_SPM   = 2;
	localparam int CFG_W     = 3;
	localparam int DEV_FEAT  = 0;

	// Filled-set codes
	localparam logic [1:0] SETS_FULL = 2'h3;
	localparam logic [1:0] SETS_ONE  = 2'h1;

	// Token kinds, one-hot
	typedef enum logic [2:0] {
		TOK_OUT   = 3'b001,
		TOK_SETUP = 3'b010,
		TOK_IN    = 3'b100
	} tokKind_t;

	// Transaction tracker states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_DATA = 2'b10
	} txnState_t;

	typedef struct packed {
		tokKind_t        kind;
		logic [EP_W-1:0] ep;
		logic            iso;
	} token_t;

	typedef struct packed {
		logic crcErr;
		logic stuffErr;
		logic fifoErr;
	} rxResult_t;

	typedef struct packed {
		logic [1:0] rxFilledSets;
		logic       rxUnderrunFlag;
		logic       rxOverrunFlag;
	} rxFifoState_t;

	typedef struct packed {
		logic ack;
		logic nak;
		logic stall;
	} handshake_t;

	typedef struct packed {
		logic voidHit;
		logic err;
	} rxOutcome_t;
endpackage
`default_nettype wire

/* core/rx_ep_status.sv */
/*
  Per-endpoint receive status: void, error and acknowledge flags plus setup pending.
  Assumes the parent gives one-cycle pulses for transaction end and start-of-frame.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_ep_status
	import usb_ep_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// Transaction results
	input  wire logic                   endNow,
	input  wire logic                   isoEnd,
	input  wire logic                   sof,
	input  wire usb_ep_pkg::rxOutcome_t outcome,
	// Setup pending control
	input  wire logic                   setupSet,
	input  wire logic                   setupClr,
	// Flags
	output logic                        rxVoidFlag,
	output logic                        rxErrorFlag,
	output logic                        rxAckFlag,
	output logic                        setupPendingFlag,
	output logic                        rxDoneEventBit
);
	import usb_ep_pkg::*;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	rxOutcome_t pend_q;
	logic       pendValid_q;
	logic       apply;
	rxOutcome_t applyVal;

	// Iso results wait for the next frame start
	assign apply    = endNow | (sof & pendValid_q);
	assign applyVal = endNow ? outcome : pend_q;

	// Iso result parking
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q      <= '0;
			pendValid_q <= 1'b0;
		end else if (isoEnd) begin
			pend_q      <= outcome;
			pendValid_q <= 1'b1;
		end else if (sof) begin
			pendValid_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rxVoidFlag  <= 1'b0;
			rxErrorFlag <= 1'b0;
			rxAckFlag   <= 1'b0;
		end else if (apply) begin
			rxVoidFlag <= applyVal.voidHit;
			if (!applyVal.voidHit) begin
				rxErrorFlag <= applyVal.err;
				rxAckFlag   <= ~applyVal.err;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rxDoneEventBit <= 1'b0;
		end else begin
			rxDoneEventBit <= apply & ~applyVal.voidHit;
		end
	end

	// set wins over the firmware clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			setupPendingFlag <= 1'b0;
		end else if (setupSet) begin
			setupPendingFlag <= 1'b1;
		end else if (setupClr) begin
			setupPendingFlag <= 1'b0;
		end
	end

	chk_void_now_set: assert property (endNow && outcome.voidHit |=> rxVoidFlag)
		else $error("void flag not set at transaction end");
	chk_iso_flag_hold: assert property (isoEnd && !sof && !endNow
		|=> $stable({rxVoidFlag, rxErrorFlag, rxAckFlag}))
		else $error("iso result applied before frame start");
	chk_err_ack_excl: assert property (apply && !applyVal.voidHit
		|=> (rxErrorFlag != rxAckFlag) && rxDoneEventBit)
		else $error("error and ack flags not exclusive");
	chk_ack_good_data: assert property (endNow && !outcome.voidHit && !outcome.err
		|=> rxAckFlag && rxDoneEventBit ##1 (!rxDoneEventBit || $past(apply)))
		else $error("ack flag missing after good data");
endmodule
`default_nettype wire

/* testbench/usb_host_model.sv */
/*
  Stand-in for the host and serial engine: tokens, data-stage ends, frame starts, bus reset.
  Assumes the bench calls one task at a time from one process.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
	import usb_ep_pkg::*;
(
	// Clock
	input  wire logic                     clk,
	// Link toward the device
	output logic                          tokStrobe,
	output usb_ep_pkg::token_t            tokInfo,
	output usb_ep_pkg::rxFifoState_t      rxFifo,
	output logic                          rxDone,
	output usb_ep_pkg::rxResult_t         rxResult,
	output logic                          sof,
	output logic                          usbReset,
	input  wire usb_ep_pkg::handshake_t   handshake
);
	import usb_ep_pkg::*;
	handshake_t lastHs;
	initial begin
		{tokStrobe, tokInfo, rxFifo, rxDone, rxResult, sof, usbReset} = '0;
		lastHs = '0;
	end
	// Latch any handshake pulse; it stands one cycle only
	always @(posedge clk) begin
		if (|handshake)
			lastHs <= handshake;
	end
	// One transaction; qualifiers go stale once the strobe drops
	task automatic xfer(input tokKind_t k, input logic [3:0] ep, input logic iso,
		input logic [1:0] sets, input rxResult_t r, input logic [1:0] fe = 2'b00);
		lastHs = '0;
		@(posedge clk);
		tokStrobe <= 1'b1;
		tokInfo <= '{k, ep, iso};
		rxFifo <= '{sets, fe[1], fe[0]};
		@(posedge clk);
		tokStrobe <= 1'b0;
		tokInfo <= ~tokInfo;
		rxFifo <= ~rxFifo;
		if (k != TOK_IN) begin
			repeat (2) @(posedge clk);
			rxDone <= 1'b1;
			rxResult <= r;
			@(posedge clk);
			rxDone <= 1'b0;
			rxResult <= ~r;
		end
		repeat (4) @(posedge clk);
	endtask
	// Single-cycle frame start or bus reset
	task automatic pulse(input logic isReset);
		@(posedge clk);
		if (isReset) usbReset <= 1'b1; else sof <= 1'b1;
		@(posedge clk);
		{usbReset, sof} <= 2'b00;
		repeat (3) @(posedge clk);
	endtask
endmodule
`default_nettype wire

/* testbench/usb_endpoint_rx_status_tx_count_bench.sv */
/*
  Self-checking bench: register tasks over the Avalon slave, host model on the link side.
  Assumes the device answers every access with one wait cycle or more.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_rx_status_tx_count_bench;
	import usb_ep_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [6:0] address = '0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = '0;
	logic [31:0] readdata;
	logic waitrequest;
	logic tokStrobe, rxDone, sof, usbReset, txByteWe, irq;
	token_t tokInfo;
	rxFifoState_t rxFifo;
	rxResult_t rxResult;
	handshake_t handshake;
	logic [7:0] txByteData;
	logic [3:0] txByteEp;
	logic [9:0] txWrPtr;
	logic [21:0] txSeen = '0;
	logic [3:0] byteEn = 4'h1;
	logic txSetSent = 1'b0;
	logic [3:0] txSentEp = '0;
	int badCount = 0;
	int checksDone = 0;
	always #25 clk = ~clk;
	// Remember the last byte pushed into the transmit FIFO
	always @(posedge clk) begin
		if (txByteWe === 1'b1)
			txSeen <= {txByteEp, txWrPtr, txByteData};
	end
	usb_endpoint_rx_status_tx_count u_dut (.clk(clk), .rst_n(rst_n), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteEn),
		.readdata(readdata), .waitrequest(waitrequest), .tokStrobe(tokStrobe),
		.tokInfo(tokInfo), .rxFifo(rxFifo), .rxDone(rxDone), .rxResult(rxResult),
		.sof(sof), .usbReset(usbReset), .txSetSent(txSetSent), .txSentEp(txSentEp),
		.handshake(handshake), .txByteWe(txByteWe), .txByteData(txByteData),
		.txByteEp(txByteEp), .txWrPtr(txWrPtr), .irq(irq));
	usb_host_model u_host (.clk(clk), .tokStrobe(tokStrobe), .tokInfo(tokInfo),
		.rxFifo(rxFifo), .rxDone(rxDone), .rxResult(rxResult), .sof(sof),
		.usbReset(usbReset), .handshake(handshake));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			badCount++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Hold the request until waitrequest is sampled low
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		address <= a;
		writedata <= {24'h0, d};
		write <= 1'b1;
		do @(posedge clk); while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask
	task automatic rdchk(input logic [6:0] a, input logic [31:0] exp);
		@(posedge clk);
		address <= a;
		read <= 1'b1;
		do @(posedge clk); while (waitrequest !== 1'b0);
		chk(readdata, exp);
		read <= 1'b0;
	endtask
	task automatic hs(input logic [2:0] e);
		chk({29'h0, u_host.lastHs}, {29'h0, e});
	endtask
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Cuts a hang short well past the expected run length
	initial begin
		repeat (6000) @(posedge clk);
		badCount++;
		report_and_stop;
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rdchk(7'h34, 0);
		rdchk(7'h40, 0);
		rdchk(7'h04, 0);
		rdchk(7'h08, 0);
		rdchk(7'h7c, 0);
		$display("reset values done");
		wr(7'h40, 8'ha5);
		rdchk(7'h40, 32'h25);
		u_host.pulse(1'b1);
		rdchk(7'h40, 32'h25);
		wr(7'h4c, 8'h01);
		u_host.pulse(1'b1);
		rdchk(7'h40, 0);
		// Write with its low byte lane off must be ignored
		byteEn <= 4'h0;
		wr(7'h40, 8'h11);
		byteEn <= 4'h1;
		rdchk(7'h40, 0);
		$display("address done");
		wr(7'h44, 8'h03);
		wr(7'h00, 8'h5a);
		// Byte pulse lands one edge later, capture one more
		repeat (2) @(posedge clk);
		chk({10'h0, txSeen}, {10'h0, 4'h3, 10'h000, 8'h5a});
		wr(7'h00, 8'h3c);
		repeat (2) @(posedge clk);
		chk({10'h0, txSeen}, {10'h0, 4'h3, 10'h001, 8'h3c});
		// High half first, then low commits the set
		wr(7'h08, 8'h03);
		rdchk(7'h08, 32'h03);
		wr(7'h04, 8'h40);
		rdchk(7'h60, 32'h01);
		wr(7'h08, 8'h00);
		wr(7'h04, 8'h00);
		rdchk(7'h60, 32'h02);
		// One set sent by the engine frees a slot
		txSentEp <= 4'h3;
		txSetSent <= 1'b1;
		@(posedge clk);
		txSetSent <= 1'b0;
		rdchk(7'h60, 32'h01);
		$display("transmit done");
		wr(7'h48, 8'h01);
		wr(7'h58, 8'h08);
		u_host.xfer(TOK_OUT, 4'h3, 1'b0, 2'h0, '0);
		hs(3'b100);
		chk({31'h0, irq}, 32'h1);
		rdchk(7'h34, 32'h01);
		rdchk(7'h50, 32'h08);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		u_host.xfer(TOK_OUT, 4'h3, 1'b0, 2'h0, '{1'b1, 1'b0, 1'b0});
		hs(3'b000);
		rdchk(7'h34, 32'h02);
		u_host.xfer(TOK_OUT, 4'h3, 1'b1, 2'h0, '0);
		rdchk(7'h34, 32'h02);
		u_host.pulse(1'b0);
		rdchk(7'h34, 32'h01);
		u_host.xfer(TOK_OUT, 4'h3, 1'b0, 2'h3, '0);
		hs(3'b010);
		rdchk(7'h34, 32'h05);
		u_host.xfer(TOK_OUT, 4'h5, 1'b0, 2'h0, '0);
		rdchk(7'h34, 32'h05);
		wr(7'h44, 8'h05);
		rdchk(7'h34, 32'h04);
		wr(7'h44, 8'h03);
		wr(7'h48, 8'h05);
		u_host.xfer(TOK_OUT, 4'h3, 1'b0, 2'h1, '0);
		hs(3'b010);
		wr(7'h48, 8'h03);
		u_host.xfer(TOK_OUT, 4'h3, 1'b0, 2'h0, '0);
		hs(3'b001);
		// FIFO underrun voids; a stuffing error gives no handshake
		wr(7'h48, 8'h01);
		u_host.xfer(TOK_OUT, 4'h3, 1'b0, 2'h0, '0, 2'b10);
		hs(3'b010);
		u_host.xfer(TOK_OUT, 4'h3, 1'b0, 2'h0, '{1'b0, 1'b1, 1'b0});
		hs(3'b000);
		rdchk(7'h34, 32'h02);
		$display("receive flags done");
		wr(7'h48, 8'h01);
		u_host.xfer(TOK_SETUP, 4'h3, 1'b0, 2'h0, '0);
		rdchk(7'h34, {24'h0, 8'h41});
		u_host.xfer(TOK_IN, 4'h3, 1'b0, 2'h0, '0);
		hs(3'b010);
		wr(7'h34, 8'h00);
		u_host.xfer(TOK_IN, 4'h3, 1'b0, 2'h0, '0);
		hs(3'b000);
		$display("setup done");
		report_and_stop;
	end
endmodule
`default_nettype wire
